/* src/chgst_pkg.sv */
// What this block does
// - Detecting variant reports eight source type codes
// - Reduced variant reports only four source codes
// - Detected current limit goes to setting register
// - Charge phase: idle, precharge, fast, done
// - Status bit 2 shows power good
// - Status bit 1 always reads zero
// - Status bit 0 shows minimum system regulation
// - Fault bit 7 shows watchdog expiry
// - Fault bit 6 shows boost fault
// - Charge error code: normal, input, thermal, timer
// - Fault bit 3 shows battery overvoltage
// - Buck thermistor codes: normal, warm, cool, cold, hot
// - Boost thermistor codes: normal, cold, hot only
// - Threshold bit 7 selects absolute method
// - Absolute code 2.6V plus 100mV, reset 0x12
// - Codes below 0x0d take effect as 0x0d
// - Relative method: code read-only, internally updated
// - Absolute method: software code stored, read back
// - Result bit 7 shows thermal regulation
// - Low seven bits hold battery voltage result
// - Ship mode bit survives watchdog reset
package chgst_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CHGST_OFS_SRC   = 8'h0b;
  localparam logic [7:0] CHGST_OFS_FAULT = 8'h0c;
  localparam logic [7:0] CHGST_OFS_VTH   = 8'h0d;
  localparam logic [7:0] CHGST_OFS_BATTERY_VOLTAGE_RESULT  = 8'h0e;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHGST_BIT_PG    = 2;
  localparam int CHGST_BIT_RSVD  = 1;
  localparam int CHGST_BIT_VSYS  = 0;
  localparam int CHGST_BIT_WDOG  = 7;
  localparam int CHGST_BIT_BOOST = 6;
  localparam int CHGST_BIT_BOV   = 3;
  localparam int CHGST_BIT_SEL   = 7;
  localparam int CHGST_BIT_THERM = 7;
  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CHGST_SRC_NONE    = 3'h0;
  localparam logic [2:0] CHGST_SRC_SDP     = 3'h1;
  localparam logic [2:0] CHGST_SRC_ADAPTER = 3'h2;
  localparam logic [2:0] CHGST_SRC_OTG     = 3'h7;
  localparam logic [1:0] CHGST_PH_IDLE = 2'h0;
  localparam logic [1:0] CHGST_PH_PRE  = 2'h1;
  localparam logic [1:0] CHGST_PH_FAST = 2'h2;
  localparam logic [1:0] CHGST_PH_DONE = 2'h3;
  localparam logic [1:0] CHGST_CF_NORMAL = 2'h0;
  localparam logic [1:0] CHGST_CF_INPUT  = 2'h1;
  localparam logic [1:0] CHGST_CF_THERM  = 2'h2;
  localparam logic [1:0] CHGST_CF_TIMER  = 2'h3;
  localparam logic [2:0] CHGST_NTC_NORMAL = 3'h0;
  localparam logic [2:0] CHGST_NTC_WARM   = 3'h2;
  localparam logic [2:0] CHGST_NTC_COOL   = 3'h3;
  localparam logic [2:0] CHGST_NTC_COLD   = 3'h5;
  localparam logic [2:0] CHGST_NTC_HOT    = 3'h6;
  localparam logic [6:0] CHGST_VTH_RESET  = 7'h12;
  localparam logic [6:0] CHGST_VTH_MIN    = 7'h0d;
  localparam int         CHGST_VTH_OFS_MV = 2600;
  localparam int         CHGST_VTH_LSB_MV = 100;
  localparam logic [6:0] CHGST_BATTERY_VOLTAGE_RESULT_RESET = 7'h00;
  localparam int         CHGST_BATTERY_VOLTAGE_RESULT_OFS_MV = 2304;
  localparam int         CHGST_BATTERY_VOLTAGE_RESULT_LSB_MV = 20;
endpackage

/* src/chgst_regs.sv */
`timescale 1ns/1ps
module chgst_regs
  import chgst_pkg::*;
#(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       sw_reset,
  input  wire logic       wdog_reset,
  // Host register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // Source and charge status
  input  wire logic [2:0] src_detect_code,
  output logic            ilim_reload,
  input  wire logic       charging,
  input  wire logic       batt_below_lowv,
  input  wire logic       term_done,
  input  wire logic       power_good,
  input  wire logic       in_minimum_system_voltage_reg,
  // Fault conditions
  input  wire logic       wdog_expired,
  input  wire logic       boost_overload,
  input  wire logic       boost_ovp,
  input  wire logic       boost_batt_low,
  input  wire logic       input_fault,
  input  wire logic       thermal_shutdown,
  input  wire logic       safety_timer_expired,
  input  wire logic       batt_ovp,
  input  wire logic       boost_mode,
  input  wire logic       ts_warm,
  input  wire logic       ts_cool,
  input  wire logic       ts_cold,
  input  wire logic       ts_hot,
  // Input voltage threshold
  input  wire logic [6:0] relative_code,
  input  wire logic       relative_load,
  output logic      [6:0] vth_effective_code,
  output logic            vth_absolute,
  // Thermal and battery voltage
  input  wire logic       thermal_reg,
  input  wire logic [6:0] battery_voltage_result_conv,
  input  wire logic       battery_voltage_result_conv_valid,
  // Ship mode
  input  wire logic       ship_off_wr,
  input  wire logic       ship_off_wdata,
  output logic            ship_mode_switch_off
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] chgst_clamp(input logic [6:0] code);
    chgst_clamp = (code < CHGST_VTH_MIN) ? CHGST_VTH_MIN : code;
  endfunction

  function automatic logic [2:0] chgst_src_map(input logic [2:0] code);
    if (!REDUCED_VARIANT) begin
      chgst_src_map = code;
    end else if (code == CHGST_SRC_NONE || code == CHGST_SRC_SDP || code == CHGST_SRC_OTG) begin
      chgst_src_map = code;
    end else begin
      // Reduced part folds every dedicated adapter kind into one code
      chgst_src_map = CHGST_SRC_ADAPTER;
    end
  endfunction

  logic       wr_src;
  logic       wr_vth;
  logic       rd_fault;
  logic [2:0] src_reg;
  logic [1:0] phase_reg;
  logic       pg_reg;
  logic       vsys_reg;
  logic       wdog_reg;
  logic       boost_reg;
  logic [1:0] cfault_reg;
  logic       bov_reg;
  logic [2:0] ntc_reg;
  logic       sel_reg;
  logic [6:0] code_reg;
  logic       therm_reg;
  logic [6:0] battery_voltage_result_reg;
  logic [7:0] rdata_next;
  logic       boost_evt;

  assign wr_src    = clk_en && reg_wr;
  assign wr_vth    = wr_src && reg_addr == CHGST_OFS_VTH;
  assign rd_fault  = clk_en && reg_rd && reg_addr == CHGST_OFS_FAULT;
  assign boost_evt = boost_overload || boost_ovp || boost_batt_low;

  // ----------------------------------------------------------------
  // Live status capture
  // ----------------------------------------------------------------
  // Writes never reach these flops; only the hardware inputs do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_reg    <= CHGST_SRC_NONE;
      phase_reg  <= CHGST_PH_IDLE;
      pg_reg     <= 1'b0;
      vsys_reg   <= 1'b0;
      cfault_reg <= CHGST_CF_NORMAL;
      bov_reg    <= 1'b0;
      ntc_reg    <= CHGST_NTC_NORMAL;
      therm_reg  <= 1'b0;
    end else if (clk_en) begin
      src_reg <= chgst_src_map(src_detect_code);
      if (!charging) begin
        phase_reg <= CHGST_PH_IDLE;
      end else if (term_done) begin
        phase_reg <= CHGST_PH_DONE;
      end else if (batt_below_lowv) begin
        phase_reg <= CHGST_PH_PRE;
      end else begin
        phase_reg <= CHGST_PH_FAST;
      end
      pg_reg   <= power_good;
      vsys_reg <= in_minimum_system_voltage_reg;
      // Thermal shutdown outranks the timer, which outranks an input fault
      if (thermal_shutdown) begin
        cfault_reg <= CHGST_CF_THERM;
      end else if (safety_timer_expired) begin
        cfault_reg <= CHGST_CF_TIMER;
      end else if (input_fault) begin
        cfault_reg <= CHGST_CF_INPUT;
      end else begin
        cfault_reg <= CHGST_CF_NORMAL;
      end
      bov_reg <= batt_ovp;
      if (ts_hot) begin
        ntc_reg <= CHGST_NTC_HOT;
      end else if (ts_cold) begin
        ntc_reg <= CHGST_NTC_COLD;
      end else if (!boost_mode && ts_warm) begin
        ntc_reg <= CHGST_NTC_WARM;
      end else if (!boost_mode && ts_cool) begin
        ntc_reg <= CHGST_NTC_COOL;
      end else begin
        ntc_reg <= CHGST_NTC_NORMAL;
      end
      therm_reg <= thermal_reg;
    end
  end

  // ----------------------------------------------------------------
  // Source change notice
  // ----------------------------------------------------------------
  // The limit itself lives in the setting register; this only asks it to reload
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ilim_reload <= 1'b0;
    end else if (clk_en) begin
      ilim_reload <= chgst_src_map(src_detect_code) != src_reg;
    end
  end

  // ----------------------------------------------------------------
  // Latched faults
  // ----------------------------------------------------------------
  // Cleared by reading the fault register; a new event in that cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdog_reg  <= 1'b0;
      boost_reg <= 1'b0;
    end else if (clk_en) begin
      wdog_reg  <= (wdog_reg && !rd_fault) || wdog_expired;
      boost_reg <= (boost_reg && !rd_fault) || boost_evt;
    end
  end

  // ----------------------------------------------------------------
  // Input voltage threshold
  // ----------------------------------------------------------------
  // Only software reset or rst clears it; the watchdog leaves it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg  <= 1'b0;
      code_reg <= CHGST_VTH_RESET;
    end else if (clk_en) begin
      if (sw_reset) begin
        sel_reg  <= 1'b0;
        code_reg <= CHGST_VTH_RESET;
      end else begin
        if (wr_vth) begin
          sel_reg <= reg_wdata[CHGST_BIT_SEL];
        end
        if (!sel_reg && relative_load) begin
          code_reg <= relative_code;
        end else if (wr_vth && reg_wdata[CHGST_BIT_SEL]) begin
          code_reg <= reg_wdata[6:0];
        end
      end
    end
  end

  assign vth_absolute       = sel_reg;
  assign vth_effective_code = chgst_clamp(code_reg);

  // ----------------------------------------------------------------
  // Battery voltage result
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      battery_voltage_result_reg <= CHGST_BATTERY_VOLTAGE_RESULT_RESET;
    end else if (clk_en && battery_voltage_result_conv_valid) begin
      battery_voltage_result_reg <= battery_voltage_result_conv;
    end
  end

  // ----------------------------------------------------------------
  // Ship mode control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ship_mode_switch_off <= 1'b0;
    end else if (clk_en) begin
      if (sw_reset) begin
        ship_mode_switch_off <= 1'b0;
      end else if (ship_off_wr) begin
        ship_mode_switch_off <= ship_off_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_addr)
      CHGST_OFS_SRC:   rdata_next = {src_reg, phase_reg, pg_reg, 1'b0, vsys_reg};
      CHGST_OFS_FAULT: rdata_next = {wdog_reg, boost_reg, cfault_reg, bov_reg, ntc_reg};
      CHGST_OFS_VTH:   rdata_next = {sel_reg, code_reg};
      CHGST_OFS_BATTERY_VOLTAGE_RESULT:  rdata_next = {therm_reg, battery_voltage_result_reg};
      default:         rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_src_read;
    clk_en && reg_rd && reg_addr == CHGST_OFS_SRC;
  endsequence

  sequence s_rdata_out;
    clk_en && reg_rvalid;
  endsequence

  property p_src_map;
    @(posedge clk) disable iff (rst) clk_en && !REDUCED_VARIANT |=> src_reg == $past(src_detect_code);
  endproperty
  a_src_map: assert property (p_src_map) else $error("source code not passed through");

  property p_src_reduced;
    @(posedge clk) disable iff (rst) REDUCED_VARIANT |-> src_reg inside {3'h0, 3'h1, 3'h2, 3'h7};
  endproperty
  a_src_reduced: assert property (p_src_reduced) else $error("reduced source code out of set");

  property p_phase_done;
    @(posedge clk) disable iff (rst) clk_en && charging && term_done |=> phase_reg == CHGST_PH_DONE;
  endproperty
  a_phase_done: assert property (p_phase_done) else $error("termination not reported");

  property p_pg_read;
    @(posedge clk) disable iff (rst) s_src_read ##1 s_rdata_out |-> reg_rdata[CHGST_BIT_PG] == $past(pg_reg);
  endproperty
  a_pg_read: assert property (p_pg_read) else $error("power good bit wrong on read");

  property p_rsvd_zero;
    @(posedge clk) disable iff (rst) s_src_read |=> reg_rdata[CHGST_BIT_RSVD] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one");

  property p_wdog_set;
    @(posedge clk) disable iff (rst) clk_en && wdog_expired |=> wdog_reg;
  endproperty
  a_wdog_set: assert property (p_wdog_set) else $error("watchdog fault not latched");

  property p_wdog_clear;
    @(posedge clk) disable iff (rst) rd_fault && !wdog_expired |=> !wdog_reg;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog fault not cleared by read");

  property p_boost_wins;
    @(posedge clk) disable iff (rst) clk_en && boost_evt && rd_fault |=> boost_reg;
  endproperty
  a_boost_wins: assert property (p_boost_wins) else $error("boost event lost to clearing read");

  property p_ntc_boost;
    @(posedge clk) disable iff (rst) clk_en && boost_mode |=> ntc_reg inside {3'h0, 3'h5, 3'h6};
  endproperty
  a_ntc_boost: assert property (p_ntc_boost) else $error("boost thermistor code illegal");

  property p_clamp;
    @(posedge clk) disable iff (rst) vth_effective_code >= CHGST_VTH_MIN && (code_reg < CHGST_VTH_MIN || vth_effective_code == code_reg);
  endproperty
  a_clamp: assert property (p_clamp) else $error("threshold clamp wrong");

  property p_code_ro;
    @(posedge clk) disable iff (rst) clk_en && !sel_reg && !relative_load && !sw_reset && !(wr_vth && reg_wdata[CHGST_BIT_SEL]) |=> $stable(code_reg);
  endproperty
  a_code_ro: assert property (p_code_ro) else $error("threshold code changed while read-only");

  property p_code_rw;
    @(posedge clk) disable iff (rst) wr_vth && reg_wdata[CHGST_BIT_SEL] && !sw_reset && !(!sel_reg && relative_load) |=> sel_reg && code_reg == $past(reg_wdata[6:0]);
  endproperty
  a_code_rw: assert property (p_code_rw) else $error("absolute code not stored");

  property p_ship_keep;
    @(posedge clk) disable iff (rst) clk_en && wdog_reset && !sw_reset && !ship_off_wr |=> $stable(ship_mode_switch_off);
  endproperty
  a_ship_keep: assert property (p_ship_keep) else $error("ship mode bit lost on watchdog reset");

  property p_ro_write;
    @(posedge clk) disable iff (rst) wr_src && reg_addr == CHGST_OFS_BATTERY_VOLTAGE_RESULT && !battery_voltage_result_conv_valid |=> $stable(battery_voltage_result_reg);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write reached read-only register");

endmodule

/* tb/chgst_host_model.sv */
`timescale 1ns/1ps
module chgst_host_model (
  // Clock
  input  logic       clk,
  // Register port toward the device
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd,
  input  logic [7:0] reg_rdata,
  input  logic       reg_rvalid
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  // Address and data are scrambled once released so a design that
  // samples them late cannot pass by luck
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk) #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk) #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
    v        = reg_rvalid;
  endtask
endmodule

/* tb/charger_status_and_input_voltage_threshold_code_regs_tb.sv */
`timescale 1ns/1ps
module charger_status_and_input_voltage_threshold_code_regs_tb;
  import chgst_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sw_reset = 0, wdog_reset = 0, ilim_reload, vth_absolute, ship_mode_switch_off;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, reg_rvalid;
  logic [2:0] src_code = 0;
  logic       charging = 0, batt_low = 0, term_done = 0, power_good = 0, vsys = 0;
  logic       wdog_exp = 0, b_ovl = 0, b_ovp = 0, b_low = 0, in_flt = 0, t_sd = 0, t_tmr = 0;
  logic       batt_ovp = 0, boost_mode = 0, warm = 0, cool = 0, cold = 0, hot = 0;
  logic [6:0] rel_code = 0, battery_voltage_result_conv = 0, vth_effective_code;
  logic       rel_load = 0, thermal_reg = 0, battery_voltage_result_valid = 0, ship_wr = 0, ship_wd = 0;
  logic       clk_en = 1'b1;
  logic [7:0] red_rdata, exp_src;
  logic [15:0] lfsr = 16'd19095;
  int          bad_count = 0, num_checks = 0, cycles = 0, i, k, n;
  always #5 clk = ~clk;
  chgst_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  chgst_regs #(.REDUCED_VARIANT(1'b0)) dut (.clk(clk), .rst(rst), .clk_en(clk_en), .sw_reset(sw_reset),
    .wdog_reset(wdog_reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .src_detect_code(src_code), .ilim_reload(ilim_reload),
    .charging(charging), .batt_below_lowv(batt_low), .term_done(term_done), .power_good(power_good),
    .in_minimum_system_voltage_reg(vsys), .wdog_expired(wdog_exp), .boost_overload(b_ovl), .boost_ovp(b_ovp),
    .boost_batt_low(b_low), .input_fault(in_flt), .thermal_shutdown(t_sd), .safety_timer_expired(t_tmr),
    .batt_ovp(batt_ovp), .boost_mode(boost_mode), .ts_warm(warm), .ts_cool(cool), .ts_cold(cold),
    .ts_hot(hot), .relative_code(rel_code), .relative_load(rel_load), .vth_effective_code(vth_effective_code),
    .vth_absolute(vth_absolute), .thermal_reg(thermal_reg), .battery_voltage_result_conv(battery_voltage_result_conv),
    .battery_voltage_result_conv_valid(battery_voltage_result_valid), .ship_off_wr(ship_wr), .ship_off_wdata(ship_wd),
    .ship_mode_switch_off(ship_mode_switch_off));
  // Reduced variant shares every input; only its read data is watched
  chgst_regs #(.REDUCED_VARIANT(1'b1)) dut_red (.clk(clk), .rst(rst), .clk_en(clk_en), .sw_reset(sw_reset),
    .wdog_reset(wdog_reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(red_rdata), .reg_rvalid(), .src_detect_code(src_code), .ilim_reload(),
    .charging(charging), .batt_below_lowv(batt_low), .term_done(term_done), .power_good(power_good),
    .in_minimum_system_voltage_reg(vsys), .wdog_expired(wdog_exp), .boost_overload(b_ovl), .boost_ovp(b_ovp),
    .boost_batt_low(b_low), .input_fault(in_flt), .thermal_shutdown(t_sd), .safety_timer_expired(t_tmr),
    .batt_ovp(batt_ovp), .boost_mode(boost_mode), .ts_warm(warm), .ts_cool(cool), .ts_cold(cold),
    .ts_hot(hot), .relative_code(rel_code), .relative_load(rel_load), .vth_effective_code(),
    .vth_absolute(), .thermal_reg(thermal_reg), .battery_voltage_result_conv(battery_voltage_result_conv),
    .battery_voltage_result_conv_valid(battery_voltage_result_valid), .ship_off_wr(ship_wr), .ship_off_wdata(ship_wd),
    .ship_mode_switch_off());
  // ----------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [2:0] red_src(input logic [2:0] c);
    return (c == 3'h0 || c == 3'h1 || c == 3'h7) ? c : 3'h2;
  endfunction
  function automatic logic [7:0] src_exp();
    logic [1:0] ph;
    ph = !charging ? 2'h0 : term_done ? 2'h3 : batt_low ? 2'h1 : 2'h2;
    return {src_code, ph, power_good, 1'b0, vsys};
  endfunction
  function automatic logic [7:0] fault_exp();
    logic [1:0] cf;
    logic [2:0] nt;
    cf = t_sd ? 2'h2 : t_tmr ? 2'h3 : in_flt ? 2'h1 : 2'h0;
    nt = hot ? 3'h6 : cold ? 3'h5 : boost_mode ? 3'h0 : warm ? 3'h2 : cool ? 3'h3 : 3'h0;
    return {2'b00, cf, batt_ovp, nt};
  endfunction
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.read_reg(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk) #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    rd_chk(CHGST_OFS_VTH, 8'h12);
    rd_chk(CHGST_OFS_BATTERY_VOLTAGE_RESULT, 8'h00);
    check({1'b0, vth_effective_code}, 8'h12);
    rd_chk(8'h3f, 8'h00);
    // Every source code once, random status levels, one reload per change
    for (i = 1; i <= 8; i++) begin
      lfsr = lfsr_next(lfsr);
      {charging, term_done, batt_low, power_good, vsys} = lfsr[4:0];
      src_code = i[2:0];
      n = 0;
      for (k = 0; k < 4; k++) begin
        step(1);
        if (ilim_reload === 1'b1) n++;
      end
      check(n[7:0], 8'h01);
      exp_src = src_exp();
      rd_chk(CHGST_OFS_SRC, exp_src);
      check(red_rdata, {red_src(src_code), exp_src[4:0]});
    end
    host.write_reg(CHGST_OFS_SRC, 8'hff);
    rd_chk(CHGST_OFS_SRC, src_exp());
    // Random fault levels, buck and boost thermistor decoding
    for (i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      {in_flt, t_sd, t_tmr, batt_ovp, boost_mode, warm, cool, cold, hot} = lfsr[8:0];
      step(2);
      rd_chk(CHGST_OFS_FAULT, fault_exp());
    end
    {in_flt, t_sd, t_tmr, batt_ovp, boost_mode, warm, cool, cold, hot} = 9'h000;
    // Sticky event bits: set by a one-cycle event, cleared by a read
    for (k = 0; k < 4; k++) begin
      {wdog_exp, b_ovl, b_ovp, b_low} = 4'b1000 >> k;
      step(1);
      {wdog_exp, b_ovl, b_ovp, b_low} = 4'b0000;
      step(2);
      host.write_reg(CHGST_OFS_FAULT, 8'h00);
      rd_chk(CHGST_OFS_FAULT, (k == 0) ? 8'h80 : 8'h40);
      rd_chk(CHGST_OFS_FAULT, 8'h00);
    end
    // Events landing on the clearing read must survive it
    fork
      rd_chk(CHGST_OFS_FAULT, 8'h00);
      begin
        @(posedge clk) #1;
        {wdog_exp, b_ovp} = 2'b11;
        @(posedge clk) #1;
        {wdog_exp, b_ovp} = 2'b00;
      end
    join
    rd_chk(CHGST_OFS_FAULT, 8'hc0);
    rd_chk(CHGST_OFS_FAULT, 8'h00);
    // Enable low freezes every flop, event latches included
    clk_en = 1'b0;
    wdog_exp = 1'b1;
    step(2);
    wdog_exp = 1'b0;
    clk_en = 1'b1;
    rd_chk(CHGST_OFS_FAULT, 8'h00);
    // Threshold: relative method guards the code from the host
    host.write_reg(CHGST_OFS_VTH, 8'h05);
    rd_chk(CHGST_OFS_VTH, 8'h12);
    rel_code = 7'h20;
    rel_load = 1'b1;
    step(1);
    rel_load = 1'b0;
    rd_chk(CHGST_OFS_VTH, 8'h20);
    host.write_reg(CHGST_OFS_VTH, 8'h85);
    rd_chk(CHGST_OFS_VTH, 8'h85);
    check({vth_absolute, vth_effective_code}, 8'h8d);
    host.write_reg(CHGST_OFS_VTH, 8'h8c);
    check({1'b0, vth_effective_code}, 8'h0d);
    host.write_reg(CHGST_OFS_VTH, 8'h95);
    check({vth_absolute, vth_effective_code}, 8'h95);
    rel_load = 1'b1;
    step(1);
    rel_load = 1'b0;
    rd_chk(CHGST_OFS_VTH, 8'h95);
    sw_reset = 1'b1;
    step(1);
    sw_reset = 1'b0;
    rd_chk(CHGST_OFS_VTH, 8'h12);
    // Battery conversion result and thermal regulation
    lfsr = lfsr_next(lfsr);
    battery_voltage_result_conv = lfsr[6:0];
    battery_voltage_result_valid = 1'b1;
    thermal_reg = 1'b1;
    step(1);
    battery_voltage_result_valid = 1'b0;
    battery_voltage_result_conv = ~lfsr[6:0];
    step(1);
    host.write_reg(CHGST_OFS_BATTERY_VOLTAGE_RESULT, 8'h00);
    rd_chk(CHGST_OFS_BATTERY_VOLTAGE_RESULT, {1'b1, lfsr[6:0]});
    thermal_reg = 1'b0;
    step(2);
    rd_chk(CHGST_OFS_BATTERY_VOLTAGE_RESULT, {1'b0, lfsr[6:0]});
    // Ship bit survives the watchdog, not a software reset
    ship_wr = 1'b1;
    ship_wd = 1'b1;
    step(1);
    ship_wr = 1'b0;
    wdog_reset = 1'b1;
    step(2);
    wdog_reset = 1'b0;
    check({7'h00, ship_mode_switch_off}, 8'h01);
    sw_reset = 1'b1;
    step(1);
    sw_reset = 1'b0;
    step(1);
    check({7'h00, ship_mode_switch_off}, 8'h00);
    report_and_stop();
  end
endmodule
